// ---- design/gpab_port.sv ----
// port a / port b gpio with lcd sharing, apb register slave
//
// Function
// - a pin whose direction bit is one is driven as output.
// - a pin whose direction bit is zero is an input.
// - an output pin drives its latch bit level.
// - data writes always load the latch; only output pins show it.
// - ordinary data read of an output pin returns the latch bit.
// - ordinary data read of an input pin returns the pin level.
// - read-modify-write data reads return the latch for every pin.
// - port a uses bits 0 to 7, port b bits 0 and 1.
// - reset clears all direction bits, so pins start as inputs.
// - float bit set in stop or watch: pins hi-z, input held low.
// - float bit clear: pin state and level kept through standby.
// - port a lcd common select bit one hands the pin to lcd.
// - port b drive-line use: direction zero, select bit one.
`timescale 1ns/100ps
module gpab_port (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [gpab_pkg::APB_AW-1:0] paddr_in,
  input wire logic [gpab_pkg::APB_DW-1:0] pwdata_in,
  input wire logic rmw_read_in,
  input wire logic standby_in,
  input wire logic [gpab_pkg::PA_W-1:0] lcd_com_in,
  input wire logic [gpab_pkg::PB_W-1:0] lcd_seg_in,
  input wire logic [gpab_pkg::PA_W-1:0] a_pin_in,
  input wire logic [gpab_pkg::PB_W-1:0] b_pin_in,
  output logic [gpab_pkg::APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [gpab_pkg::PA_W-1:0] a_pin_out,
  output logic [gpab_pkg::PA_W-1:0] a_pin_oe_out,
  output logic [gpab_pkg::PB_W-1:0] b_pin_out,
  output logic [gpab_pkg::PB_W-1:0] b_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [gpab_pkg::PA_W-1:0] pa_latch_r;
  logic [gpab_pkg::PA_W-1:0] pa_dir_r;
  logic [gpab_pkg::PB_W-1:0] pb_latch_r;
  logic [gpab_pkg::PB_W-1:0] pb_dir_r;
  logic [gpab_pkg::PA_W-1:0] com_sel_r;
  logic [gpab_pkg::PB_W-1:0] seg_sel_r;
  logic input_gate_r;
  logic pin_float_r;
  logic [gpab_pkg::PA_W-1:0] a_level;
  logic [gpab_pkg::PB_W-1:0] b_level;
  logic float_act;
  logic setup_ph;
  logic wr_done;
  logic mapped;
  logic [gpab_pkg::APB_DW-1:0] rd_nxt;

  assign float_act = standby_in & pin_float_r;
  assign setup_ph = psel_in & ~penable_in;
  assign wr_done = psel_in & penable_in & pready_out & pwrite_in;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = '0;
    case (paddr_in)
      gpab_pkg::OFS_PA_LATCH:
        if (rmw_read_in)
          rd_nxt[7:0] = pa_latch_r;
        else
          rd_nxt[7:0] = (pa_latch_r & pa_dir_r) | (a_level & ~pa_dir_r);
      gpab_pkg::OFS_PA_DIR:
        rd_nxt[7:0] = pa_dir_r;
      gpab_pkg::OFS_PB_LATCH:
        if (rmw_read_in)
          rd_nxt[1:0] = pb_latch_r;
        else
          rd_nxt[1:0] = (pb_latch_r & pb_dir_r) | (b_level & ~pb_dir_r);
      gpab_pkg::OFS_PB_DIR:
        rd_nxt[1:0] = pb_dir_r;
      gpab_pkg::OFS_LCD_ENABLE_TWO:
        rd_nxt[7:0] = com_sel_r;
      gpab_pkg::OFS_LCD_ENABLE_THREE:
        rd_nxt[1:0] = seg_sel_r;
      gpab_pkg::OFS_LCD_ENABLE_ONE:
        rd_nxt[gpab_pkg::POS_PORT_INPUT_GATE] = input_gate_r;
      gpab_pkg::OFS_STANDBY_CTRL:
        rd_nxt[gpab_pkg::POS_STANDBY_PIN_FLOAT] = pin_float_r;
      default:
        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: no wait states, read data taken in the setup cycle, write data in the access cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end
    else
    begin
      pready_out <= setup_ph;
      pslverr_out <= setup_ph & ~mapped;
      if (setup_ph && !pwrite_in)
        prdata_out <= rd_nxt;
      else if (!psel_in)
        prdata_out <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port data latches; no reset needed in the part, cleared here for sim
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pa_latch_r <= gpab_pkg::RST_PA_LATCH;
      pb_latch_r <= gpab_pkg::RST_PB_LATCH;
    end
    else if (wr_done)
    begin
      if (paddr_in == gpab_pkg::OFS_PA_LATCH)
        pa_latch_r <= pwdata_in[7:0];
      if (paddr_in == gpab_pkg::OFS_PB_LATCH)
        pb_latch_r <= pwdata_in[1:0];
    end
  end

  // direction bits
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pa_dir_r <= gpab_pkg::RST_PA_DIR;
      pb_dir_r <= gpab_pkg::RST_PB_DIR;
    end
    else if (wr_done)
    begin
      if (paddr_in == gpab_pkg::OFS_PA_DIR)
        pa_dir_r <= pwdata_in[7:0];
      if (paddr_in == gpab_pkg::OFS_PB_DIR)
        pb_dir_r <= pwdata_in[1:0];
    end
  end

  // lcd sharing selects and input gate
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      com_sel_r <= gpab_pkg::RST_COM_SEL;
      seg_sel_r <= gpab_pkg::RST_SEG_SEL;
      input_gate_r <= gpab_pkg::RST_INPUT_GATE;
    end
    else if (wr_done)
    begin
      if (paddr_in == gpab_pkg::OFS_LCD_ENABLE_TWO)
        com_sel_r <= pwdata_in[7:0];
      if (paddr_in == gpab_pkg::OFS_LCD_ENABLE_THREE)
        seg_sel_r <= pwdata_in[1:0];
      if (paddr_in == gpab_pkg::OFS_LCD_ENABLE_ONE)
        input_gate_r <= pwdata_in[gpab_pkg::POS_PORT_INPUT_GATE];
    end
  end

  // standby pin float control
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pin_float_r <= gpab_pkg::RST_PIN_FLOAT;
    else if (wr_done && paddr_in == gpab_pkg::OFS_STANDBY_CTRL)
      pin_float_r <= pwdata_in[gpab_pkg::POS_STANDBY_PIN_FLOAT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // the lcd owns a selected pin even if direction is left at one
  gpab_pin_bank #(
    .W(gpab_pkg::PA_W)
  ) u_bank_a (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .dir_in(pa_dir_r),
    .latch_in(pa_latch_r),
    .lcd_sel_in(com_sel_r),
    .lcd_val_in(lcd_com_in),
    .input_gate_in(input_gate_r),
    .float_in(float_act),
    .pin_in(a_pin_in),
    .pin_out(a_pin_out),
    .pin_oe_out(a_pin_oe_out),
    .level_out(a_level)
  );

  gpab_pin_bank #(
    .W(gpab_pkg::PB_W)
  ) u_bank_b (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .dir_in(pb_dir_r),
    .latch_in(pb_latch_r),
    .lcd_sel_in(seg_sel_r),
    .lcd_val_in(lcd_seg_in),
    .input_gate_in(input_gate_r),
    .float_in(float_act),
    .pin_in(b_pin_in),
    .pin_out(b_pin_out),
    .pin_oe_out(b_pin_oe_out),
    .level_out(b_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_dir_clear:
  assert property (@(posedge clk_in)
    rst_in |=> (pa_dir_r == 8'h00) && (pb_dir_r == 2'h0))
  else
    $error("direction bits not cleared by reset");

  a_pin_dir_enable:
  assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(float_act) && !$past(rst_in) |->
    a_pin_oe_out == ($past(pa_dir_r) | $past(com_sel_r)))
  else
    $error("port a output enable does not follow direction");

  a_pin_input_off:
  assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(float_act) && !$past(rst_in) |->
    (b_pin_oe_out & ~$past(pb_dir_r) & ~$past(seg_sel_r)) == 2'h0)
  else
    $error("port b input pin is driven");

  a_pin_out_level:
  assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(float_act) && !$past(rst_in) |->
    ((a_pin_out ^ $past(pa_latch_r))
      & $past(pa_dir_r) & ~$past(com_sel_r)) == 8'h00)
  else
    $error("port a output level differs from latch");

  a_latch_write_load:
  assert property (@(posedge clk_in) disable iff (rst_in)
    wr_done && paddr_in == gpab_pkg::OFS_PA_LATCH |=>
    pa_latch_r == $past(pwdata_in[7:0]))
  else
    $error("port a latch not loaded by write");

  a_latch_pin_delay:
  assert property (@(posedge clk_in) disable iff (rst_in)
    wr_done && paddr_in == gpab_pkg::OFS_PB_LATCH && pb_dir_r == 2'h3
    && seg_sel_r == 2'h0 ##1 !float_act && $stable(pb_dir_r)
    |=> b_pin_out == $past(pwdata_in[1:0], 2))
  else
    $error("port b pins not updated one edge after latch write");

  a_read_plain_mix:
  assert property (@(posedge clk_in) disable iff (rst_in)
    setup_ph && !pwrite_in && !rmw_read_in
    && paddr_in == gpab_pkg::OFS_PA_LATCH |=>
    prdata_out[7:0] == (($past(pa_latch_r) & $past(pa_dir_r))
      | ($past(a_level) & ~$past(pa_dir_r))))
  else
    $error("ordinary port a read mixes latch and pins wrongly");

  a_read_rmw_latch:
  assert property (@(posedge clk_in) disable iff (rst_in)
    setup_ph && !pwrite_in && rmw_read_in
    && paddr_in == gpab_pkg::OFS_PB_LATCH |=>
    prdata_out == {30'h0, $past(pb_latch_r)})
  else
    $error("rmw read of port b did not return latch");

  a_read_upper_zero:
  assert property (@(posedge clk_in) disable iff (rst_in)
    setup_ph && !pwrite_in && paddr_in == gpab_pkg::OFS_PB_DIR
    |=> prdata_out[31:2] == 30'h0 && prdata_out[1:0] == $past(pb_dir_r))
  else
    $error("port b direction read shows upper bits");

  a_float_hiz:
  assert property (@(posedge clk_in) disable iff (rst_in)
    float_act |=> a_pin_oe_out == 8'h00 && b_pin_oe_out == 2'h0
    ##1 (a_level == 8'h00 || !$past(float_act)))
  else
    $error("pins not floated or input not held low in standby");

  a_standby_hold:
  assert property (@(posedge clk_in) disable iff (rst_in)
    standby_in && !pin_float_r && $stable(pa_dir_r) && $stable(com_sel_r)
    |=> a_pin_oe_out == $past(a_pin_oe_out, 1) || $past(rst_in))
  else
    $error("pin state changed in standby with float clear");

  a_lcd_common_own:
  assert property (@(posedge clk_in) disable iff (rst_in)
    !float_act && com_sel_r != 8'h00 |=>
    ((~a_pin_oe_out | (a_pin_out ^ $past(lcd_com_in)))
      & $past(com_sel_r)) == 8'h00)
  else
    $error("selected port a pin not handed to lcd common");

  a_apb_zero_wait:
  assert property (@(posedge clk_in) disable iff (rst_in)
    setup_ph |=> pready_out ##1 !pready_out || setup_ph)
  else
    $error("apb ready not a single access cycle");

endmodule

// ---- design/gpab_pkg.sv ----
// constants for the shared port a / port b gpio block
package gpab_pkg;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int PA_W = 8;
  localparam int PB_W = 2;
  // register byte offsets
  localparam logic [11:0] OFS_PA_LATCH = 12'h000;
  localparam logic [11:0] OFS_PA_DIR = 12'h004;
  localparam logic [11:0] OFS_PB_LATCH = 12'h008;
  localparam logic [11:0] OFS_PB_DIR = 12'h00C;
  localparam logic [11:0] OFS_LCD_ENABLE_TWO = 12'h010;
  localparam logic [11:0] OFS_LCD_ENABLE_THREE = 12'h014;
  localparam logic [11:0] OFS_LCD_ENABLE_ONE = 12'h018;
  localparam logic [11:0] OFS_STANDBY_CTRL = 12'h01C;
  // field positions
  localparam int POS_PORT_INPUT_GATE = 0;
  localparam int POS_STANDBY_PIN_FLOAT = 0;
  // reset values
  localparam logic [7:0] RST_PA_LATCH = 8'h00;
  localparam logic [7:0] RST_PA_DIR = 8'h00;
  localparam logic [1:0] RST_PB_LATCH = 2'h0;
  localparam logic [1:0] RST_PB_DIR = 2'h0;
  localparam logic [7:0] RST_COM_SEL = 8'h00;
  localparam logic [1:0] RST_SEG_SEL = 2'h0;
  localparam logic RST_INPUT_GATE = 1'b1;
  localparam logic RST_PIN_FLOAT = 1'b0;
endpackage

// ---- design/gpab_pin_bank.sv ----
// pin drivers and input samplers for one port
`timescale 1ns/100ps
module gpab_pin_bank #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] dir_in,
  input wire logic [W-1:0] latch_in,
  input wire logic [W-1:0] lcd_sel_in,
  input wire logic [W-1:0] lcd_val_in,
  input wire logic input_gate_in,
  input wire logic float_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out,
  output logic [W-1:0] level_out
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_pin
      // drive path; one edge after the registers change
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= 1'b0;
        end
        else if (float_in)
        begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= 1'b0;
        end
        else if (lcd_sel_in[i])
        begin
          pin_out[i] <= lcd_val_in[i];
          pin_oe_out[i] <= 1'b1;
        end
        else
        begin
          pin_out[i] <= latch_in[i];
          pin_oe_out[i] <= dir_in[i];
        end
      end

      // input path; forced low while floated to stop leakage
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          level_out[i] <= 1'b0;
        else if (float_in || !input_gate_in)
          level_out[i] <= 1'b0;
        else
          level_out[i] <= pin_in[i];
      end
    end
  endgenerate

endmodule

// ---- verif/gpab_pin_env.sv ----
// external pin model: resolves each pin wire from both of its drivers
`timescale 1ns/100ps
module gpab_pin_env #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic [W-1:0] dut_val_in,
  input wire logic [W-1:0] dut_oe_in,
  input wire logic [W-1:0] ext_val_in,
  input wire logic [W-1:0] ext_en_in,
  output logic [W-1:0] wire_out
);
  logic tog_r = 1'b0;
  // undriven pins wander so a stale level cannot pass a check
  always_ff @(posedge clk_in)
    tog_r <= ~tog_r;
  // outside driver yields wherever the block drives
  always_comb
  begin
    for (int i = 0; i < W; i++)
      wire_out[i] = dut_oe_in[i] ? dut_val_in[i] :
        (ext_en_in[i] ? ext_val_in[i] : tog_r);
  end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the port a / port b gpio block
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rmw = 1'b0;
  logic standby = 1'b0;
  logic [7:0] lcd_com = 8'h00;
  logic [1:0] lcd_seg = 2'h0;
  logic [7:0] a_ext = 8'h3C;
  logic [1:0] b_ext = 2'h2;
  logic [7:0] a_in, a_out, a_oe;
  logic [1:0] b_in, b_out, b_oe;
  logic [31:0] prdata, q;
  logic pready, pslverr, err;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  //////////////////////////////////////////////////////////////////////////
  gpab_port dut_u (.clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .rmw_read_in(rmw), .standby_in(standby),
    .lcd_com_in(lcd_com), .lcd_seg_in(lcd_seg), .a_pin_in(a_in),
    .b_pin_in(b_in), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .a_pin_out(a_out), .a_pin_oe_out(a_oe),
    .b_pin_out(b_out), .b_pin_oe_out(b_oe));
  gpab_pin_env #(.W(8)) env_a (.clk_in(clk), .dut_val_in(a_out),
    .dut_oe_in(a_oe), .ext_val_in(a_ext), .ext_en_in(8'hFF),
    .wire_out(a_in));
  gpab_pin_env #(.W(2)) env_b (.clk_in(clk), .dut_val_in(b_out),
    .dut_oe_in(b_oe), .ext_val_in(b_ext), .ext_en_in(2'h3),
    .wire_out(b_in));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
  begin
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // no release here, so calls run back to back
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic m);
  begin
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    rmw <= m;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
  end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
  begin
    apb(1'b1, a, d, 1'b0);
  end
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic m,
    input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h0, m);
    chk(nm, q, e);
  end
  endtask
  // pins lag the register by one edge, so look two edges after release
  task automatic pins(input logic [7:0] aoe, input logic [7:0] ao,
    input logic [1:0] boe, input logic [1:0] bo);
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("a_oe", 32'(a_oe), 32'(aoe));
    chk("a_out", 32'(a_out & a_oe), 32'(ao));
    chk("b_oe", 32'(b_oe), 32'(boe));
    chk("b_out", 32'(b_out & b_oe), 32'(bo));
  end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd("reset", 12'(4 * i), 1'b1, (i == 6) ? 32'h1 : 32'h0);
    pins(8'h00, 8'h00, 2'h0, 2'h0);
    apb(1'b0, 12'h020, 32'h0, 1'b0);
    chk("unmapped data", q, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    wr(gpab_pkg::OFS_PA_LATCH, 32'hA5);
    pins(8'h00, 8'h00, 2'h0, 2'h0);
    rd("a rmw", gpab_pkg::OFS_PA_LATCH, 1'b1, 32'hA5);
    rd("a in", gpab_pkg::OFS_PA_LATCH, 1'b0, 32'h3C);
    wr(gpab_pkg::OFS_PA_DIR, 32'hFFFF_FF0F);
    pins(8'h0F, 8'h05, 2'h0, 2'h0);
    rd("a mix", gpab_pkg::OFS_PA_LATCH, 1'b0, 32'h35);
    rd("a rmw mix", gpab_pkg::OFS_PA_LATCH, 1'b1, 32'hA5);
    wr(gpab_pkg::OFS_PB_LATCH, 32'hFF);
    wr(gpab_pkg::OFS_PB_DIR, 32'hFF);
    pins(8'h0F, 8'h05, 2'h3, 2'h3);
    rd("b latch", gpab_pkg::OFS_PB_LATCH, 1'b1, 32'h3);
    rd("b dir", gpab_pkg::OFS_PB_DIR, 1'b0, 32'h3);
    wr(gpab_pkg::OFS_PB_LATCH, 32'h2);
    pins(8'h0F, 8'h05, 2'h3, 2'h2);
    wr(gpab_pkg::OFS_PB_LATCH, 32'h3);
    // pin 7 direction stays zero while the lcd owns it
    lcd_com <= 8'h80;
    wr(gpab_pkg::OFS_LCD_ENABLE_TWO, 32'h80);
    pins(8'h8F, 8'h85, 2'h3, 2'h3);
    wr(gpab_pkg::OFS_LCD_ENABLE_TWO, 32'h0);
    wr(gpab_pkg::OFS_LCD_ENABLE_ONE, 32'h1);
    wr(gpab_pkg::OFS_PB_DIR, 32'h0);
    lcd_seg <= 2'h1;
    wr(gpab_pkg::OFS_LCD_ENABLE_THREE, 32'h1);
    pins(8'h0F, 8'h05, 2'h1, 2'h1);
    b_ext <= 2'h1;
    wr(gpab_pkg::OFS_LCD_ENABLE_THREE, 32'h0);
    wr(gpab_pkg::OFS_LCD_ENABLE_ONE, 32'h1);
    rd("b in", gpab_pkg::OFS_PB_LATCH, 1'b0, 32'h1);
    standby <= 1'b1;
    pins(8'h0F, 8'h05, 2'h0, 2'h0);
    rd("a hold", gpab_pkg::OFS_PA_LATCH, 1'b0, 32'h35);
    wr(gpab_pkg::OFS_STANDBY_CTRL, 32'h1);
    pins(8'h00, 8'h00, 2'h0, 2'h0);
    rd("a float", gpab_pkg::OFS_PA_LATCH, 1'b0, 32'h05);
    standby <= 1'b0;
    pins(8'h0F, 8'h05, 2'h0, 2'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("dir again", gpab_pkg::OFS_PA_DIR, 1'b0, 32'h0);
    pins(8'h00, 8'h00, 2'h0, 2'h0);
    summarize();
  end
endmodule
